// ### tx_config_params.svh
`ifndef TX_CONFIG_PARAMS_SVH
`define TX_CONFIG_PARAMS_SVH

`define TXC_ADDR_CMD       8'h00
`define TXC_ADDR_STAT2     8'h02
`define TXC_ADDR_TXOPT     8'h0F
`define TXC_ADDR_POWER     8'h18
`define TXC_ADDR_PRE       8'h1A
`define TXC_ADDR_AUX       8'h30

`define TXC_CMD_TX         8'h02
`define TXC_CMD_IDLE       8'h03
`define TXC_CMD_RETURN     8'h04

`define TXC_TXOPT_MOD      0
`define TXC_TXOPT_SHAPE    1
`define TXC_TXOPT_IDSEL    2
`define TXC_TXOPT_SMOOTH   4
`define TXC_TXOPT_FORCE    5
`define TXC_TXOPT_CCA_LO   6
`define TXC_TXOPT_MASK     8'hF7
`define TXC_POWER_RANGE    7
`define TXC_AUX_USEID      0
`define TXC_AUX_PKT        1
`define TXC_AUX_BUF        2
`define TXC_STAT2_BUSY     0
`define TXC_STAT2_BLOCKED  1
`define TXC_STAT2_CHAN_LO  4

`define TXC_TXOPT_RESET    8'h00
`define TXC_POWER_RESET    8'h00
`define TXC_PRE_RESET      8'h00
`define TXC_AUX_RESET      8'h00
`define TXC_CHAN_RESET     4'h0

`define TXC_CLK_PERIOD_NS  20
`define TXC_RAMP_STEP_NS   200
`define TXC_RAMP_STEP_CYC \
  ((`TXC_RAMP_STEP_NS + `TXC_CLK_PERIOD_NS - 1) / `TXC_CLK_PERIOD_NS)
`define TXC_RAMP_INC       8'h02
`define TXC_SHAPE_LAST     4'hF

`endif

// ### tx_config_pkg.sv
package tx_config_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CCA,
    ST_LOAD,
    ST_RAMP,
    ST_PRE,
    ST_ID,
    ST_DATA
  } txState_t;

  typedef enum logic [1:0] {
    CCA_NONE,
    CCA_SINGLE,
    CCA_MULTI,
    CCA_ILLEGAL
  } ccaMode_t;

endpackage

// ### tx_config_preamble_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_config_params.svh"

module tx_config_preamble_regs
  import tx_config_pkg::*;
#(
  parameter int ID_WIDTH = 8
) (
  input  wire logic          ref_clk,         // System clock.
  input  wire logic          srst,            // Synchronous reset.
  input  wire logic [7:0]    regAddr,         // Register address.
  input  wire logic [7:0]    regWdata,        // Register write data.
  input  wire logic          regWrite,        // Write strobe.
  input  wire logic          regRead,         // Read strobe.
  output logic      [7:0]    regRdata,        // Read data, next cycle.
  input  wire logic          bitTick,         // One pulse per bit time.
  input  wire logic          shapeTick,       // Pulse at 16x bit rate.
  input  wire logic          txDataPin,       // Transmit data pin.
  input  wire logic          burstStart,      // Burst timer start pulse.
  input  wire logic          ccaDone,         // Energy check finished.
  input  wire logic          energyDetect,    // Energy seen on channel.
  input  wire logic          pktLoaded,       // Packet is in RAM.
  input  wire logic [ID_WIDTH-1:0] chipId,    // Device identifier.
  input  wire logic [ID_WIDTH-1:0] globalId,  // Global identifier.
  output logic               rfEnable,        // RF output driver on.
  output logic               rxEnable,        // Receiver on for check.
  output logic               ccaMulti,        // Multi-channel check.
  output logic               loadReq,         // Load packet into RAM.
  output logic               txBit,           // Modulating bit.
  output logic      [3:0]    freqLevel,       // Synthesizer step level.
  output logic      [7:0]    dacCode,         // PA power DAC code.
  output logic               paRangeHigh,     // High PA range.
  output logic               modulationSelect,// On-off keying mode.
  output logic               channelForceEnable, // Channel forced.
  output logic      [3:0]    forcedChannel,   // Forced channel number.
  output logic               txBusy           // Transmit in progress.
);

  localparam int IDW = (ID_WIDTH > 1) ? $clog2(ID_WIDTH) : 1;
  // Shaping weights from 0 to 15 along a Gaussian step, entry 0 lowest.
  localparam logic [63:0] GAUSS_TABLE = 64'hFFEEDCA965321100;

  if (ID_WIDTH < 2 || ID_WIDTH > 64) begin
    $error("ID_WIDTH must lie between 2 and 64");
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] gaussStep(input logic [3:0] idx);
    return GAUSS_TABLE[{idx, 2'b00} +: 4];
  endfunction
  //////////////////////////////////////////////////////////////////////////
  logic [7:0]    txOpt_r, txOpt_nxt;
  logic [7:0]    power_r, power_nxt;
  logic [7:0]    preLen_r, preLen_nxt;
  logic [7:0]    aux_r, aux_nxt;
  logic [3:0]    chan_r, chan_nxt;
  logic          blocked_r, blocked_nxt;
  logic [7:0]    rdata_r, rdata_nxt;
  txState_t      state_r, state_nxt;
  logic [7:0]    bitCnt_r, bitCnt_nxt;
  logic [IDW-1:0] idCnt_r, idCnt_nxt;
  logic [3:0]    rampCnt_r, rampCnt_nxt;
  logic [7:0]    rampLvl_r, rampLvl_nxt;
  logic          txBit_r, txBit_nxt;
  logic          shapeOn_r, shapeOn_nxt;
  logic          shapeUp_r, shapeUp_nxt;
  logic [3:0]    shapeIdx_r, shapeIdx_nxt;
  logic [3:0]    freq_r, freq_nxt;
  logic [7:0]    dac_r, dac_nxt;
  logic          rf_r, rf_nxt;
  logic          rx_r, rx_nxt;
  logic          load_r, load_nxt;
  logic          dataMeta_r, dataSync_r;

  ccaMode_t       ccaMode;
  logic           useId;
  logic           buffered;
  logic           startCmd;
  logic           stopCmd;
  logic [7:0]     dacTarget;
  logic [ID_WIDTH-1:0] idWord;
  txState_t       afterCca;
  txState_t       afterLoad;
  txState_t       afterRamp;

  assign ccaMode   = ccaMode_t'(txOpt_r[`TXC_TXOPT_CCA_LO +: 2]);
  assign useId     = aux_r[`TXC_AUX_USEID];
  assign buffered  = aux_r[`TXC_AUX_BUF] & useId & aux_r[`TXC_AUX_PKT];
  assign dacTarget = {power_r[6:0], 1'b0};
  assign idWord    = txOpt_r[`TXC_TXOPT_IDSEL] ? chipId : globalId;
  assign startCmd  = (regWrite && regAddr == `TXC_ADDR_CMD &&
                      regWdata == `TXC_CMD_TX) || burstStart;
  assign stopCmd   = regWrite && regAddr == `TXC_ADDR_CMD &&
                     (regWdata == `TXC_CMD_IDLE ||
                      regWdata == `TXC_CMD_RETURN);

  // Each phase falls through to the next one that is enabled.
  assign afterRamp = (preLen_r != 8'h00) ? ST_PRE :
                     (useId ? ST_ID : ST_DATA);
  assign afterLoad = txOpt_r[`TXC_TXOPT_SMOOTH] ? ST_RAMP : afterRamp;
  assign afterCca  = buffered ? ST_LOAD : afterLoad;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    txOpt_nxt    = txOpt_r;
    power_nxt    = power_r;
    preLen_nxt   = preLen_r;
    aux_nxt      = aux_r;
    chan_nxt     = chan_r;
    blocked_nxt  = blocked_r;
    rdata_nxt    = 8'h00;
    state_nxt    = state_r;
    bitCnt_nxt   = bitCnt_r;
    idCnt_nxt    = idCnt_r;
    rampCnt_nxt  = rampCnt_r;
    rampLvl_nxt  = rampLvl_r;
    txBit_nxt    = txBit_r;
    shapeOn_nxt  = shapeOn_r;
    shapeUp_nxt  = shapeUp_r;
    shapeIdx_nxt = shapeIdx_r;

    if (regWrite) begin
      case (regAddr)
        `TXC_ADDR_TXOPT:  txOpt_nxt  = regWdata & `TXC_TXOPT_MASK;
        `TXC_ADDR_POWER:  power_nxt  = regWdata;
        `TXC_ADDR_PRE:    preLen_nxt = regWdata;
        `TXC_ADDR_AUX:    aux_nxt    = regWdata & 8'h07;
        `TXC_ADDR_STAT2: begin
          if (txOpt_r[`TXC_TXOPT_FORCE]) begin
            chan_nxt = regWdata[`TXC_STAT2_CHAN_LO +: 4];
          end
        end
        default: ;
      endcase
    end

    if (regRead) begin
      case (regAddr)
        `TXC_ADDR_TXOPT:  rdata_nxt = txOpt_r;
        `TXC_ADDR_POWER:  rdata_nxt = power_r;
        `TXC_ADDR_PRE:    rdata_nxt = preLen_r;
        `TXC_ADDR_AUX:    rdata_nxt = aux_r;
        `TXC_ADDR_STAT2: begin
          rdata_nxt = {chan_r, 2'b00, blocked_r, state_r != ST_IDLE};
        end
        default:          rdata_nxt = 8'h00;
      endcase
    end

    case (state_r)
      ST_IDLE: begin
        txBit_nxt   = 1'b0;
        rampLvl_nxt = 8'h00;
        rampCnt_nxt = 4'h0;
        if (startCmd) begin
          bitCnt_nxt = 8'h00;
          idCnt_nxt  = IDW'(ID_WIDTH - 1);
          if (ccaMode == CCA_SINGLE || ccaMode == CCA_MULTI) begin
            state_nxt = ST_CCA;
          end else begin
            state_nxt = afterCca;
          end
        end
      end
      ST_CCA: begin
        if (ccaDone) begin
          if (energyDetect) begin
            state_nxt   = ST_IDLE;
            blocked_nxt = 1'b1;
          end else begin
            state_nxt = afterCca;
          end
        end
      end
      ST_LOAD: begin
        if (pktLoaded) begin
          state_nxt = afterLoad;
        end
      end
      ST_RAMP: begin
        if (rampLvl_r >= dacTarget) begin
          state_nxt = afterRamp;
        end else if (rampCnt_r == 4'(`TXC_RAMP_STEP_CYC - 1)) begin
          rampCnt_nxt = 4'h0;
          rampLvl_nxt = rampLvl_r + `TXC_RAMP_INC;
        end else begin
          rampCnt_nxt = rampCnt_r + 4'h1;
        end
      end
      ST_PRE: begin
        if (bitTick) begin
          if (txOpt_r[`TXC_TXOPT_MOD]) begin
            txBit_nxt = 1'b1;
          end else begin
            txBit_nxt = ~bitCnt_r[0];
          end
          bitCnt_nxt = bitCnt_r + 8'h01;
          if (bitCnt_r == preLen_r - 8'h01) begin
            state_nxt = useId ? ST_ID : ST_DATA;
          end
        end
      end
      ST_ID: begin
        if (bitTick) begin
          txBit_nxt = idWord[idCnt_r];
          idCnt_nxt = idCnt_r - IDW'(1);
          if (idCnt_r == '0) begin
            state_nxt = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (bitTick) begin
          txBit_nxt = dataSync_r;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase

    if (stopCmd) begin
      state_nxt = ST_IDLE;
    end
    if (startCmd && state_r == ST_IDLE && !(ccaDone && energyDetect)) begin
      blocked_nxt = 1'b0;
    end

    if (txOpt_r[`TXC_TXOPT_SHAPE] && !txOpt_r[`TXC_TXOPT_MOD]) begin
      if (txBit_nxt != txBit_r) begin
        shapeOn_nxt  = 1'b1;
        shapeUp_nxt  = txBit_nxt;
        shapeIdx_nxt = 4'h0;
      end else if (shapeOn_r && shapeTick) begin
        shapeIdx_nxt = shapeIdx_r + 4'h1;
        if (shapeIdx_r == `TXC_SHAPE_LAST - 4'h1) begin
          shapeOn_nxt = 1'b0;
        end
      end
    end else begin
      shapeOn_nxt  = 1'b0;
      shapeUp_nxt  = txBit_nxt;
      shapeIdx_nxt = `TXC_SHAPE_LAST;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (shapeOn_nxt || txOpt_r[`TXC_TXOPT_SHAPE]) begin
      freq_nxt = shapeUp_nxt ? gaussStep(shapeIdx_nxt)
                             : `TXC_SHAPE_LAST - gaussStep(shapeIdx_nxt);
    end else begin
      freq_nxt = txBit_nxt ? `TXC_SHAPE_LAST : 4'h0;
    end
    dac_nxt  = (state_nxt == ST_RAMP) ? rampLvl_nxt : dacTarget;
    rx_nxt   = (state_nxt == ST_CCA);
    load_nxt = (state_nxt == ST_LOAD);
    case (state_nxt)
      ST_RAMP, ST_PRE: rf_nxt = 1'b1;
      ST_ID, ST_DATA: begin
        rf_nxt = txOpt_r[`TXC_TXOPT_MOD] ? txBit_nxt : 1'b1;
      end
      default: rf_nxt = 1'b0;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      txOpt_r    <= `TXC_TXOPT_RESET;
      power_r    <= `TXC_POWER_RESET;
      preLen_r   <= `TXC_PRE_RESET;
      aux_r      <= `TXC_AUX_RESET;
      chan_r     <= `TXC_CHAN_RESET;
      blocked_r  <= 1'b0;
      rdata_r    <= 8'h00;
      state_r    <= ST_IDLE;
      bitCnt_r   <= 8'h00;
      idCnt_r    <= '0;
      rampCnt_r  <= 4'h0;
      rampLvl_r  <= 8'h00;
      txBit_r    <= 1'b0;
      shapeOn_r  <= 1'b0;
      shapeUp_r  <= 1'b0;
      shapeIdx_r <= `TXC_SHAPE_LAST;
      freq_r     <= 4'h0;
      dac_r      <= 8'h00;
      rf_r       <= 1'b0;
      rx_r       <= 1'b0;
      load_r     <= 1'b0;
      dataMeta_r <= 1'b0;
      dataSync_r <= 1'b0;
    end else begin
      txOpt_r    <= txOpt_nxt;
      power_r    <= power_nxt;
      preLen_r   <= preLen_nxt;
      aux_r      <= aux_nxt;
      chan_r     <= chan_nxt;
      blocked_r  <= blocked_nxt;
      rdata_r    <= rdata_nxt;
      state_r    <= state_nxt;
      bitCnt_r   <= bitCnt_nxt;
      idCnt_r    <= idCnt_nxt;
      rampCnt_r  <= rampCnt_nxt;
      rampLvl_r  <= rampLvl_nxt;
      txBit_r    <= txBit_nxt;
      shapeOn_r  <= shapeOn_nxt;
      shapeUp_r  <= shapeUp_nxt;
      shapeIdx_r <= shapeIdx_nxt;
      freq_r     <= freq_nxt;
      dac_r      <= dac_nxt;
      rf_r       <= rf_nxt;
      rx_r       <= rx_nxt;
      load_r     <= load_nxt;
      dataMeta_r <= txDataPin;
      dataSync_r <= dataMeta_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  assign regRdata           = rdata_r;
  assign rfEnable           = rf_r;
  assign rxEnable           = rx_r;
  assign ccaMulti           = (ccaMode == CCA_MULTI);
  assign loadReq            = load_r;
  assign txBit              = txBit_r;
  assign freqLevel          = freq_r;
  assign dacCode            = dac_r;
  assign paRangeHigh        = power_r[`TXC_POWER_RANGE];
  assign modulationSelect   = txOpt_r[`TXC_TXOPT_MOD];
  assign channelForceEnable = txOpt_r[`TXC_TXOPT_FORCE];
  assign forcedChannel      = chan_r;
  assign txBusy             = (state_r != ST_IDLE);

endmodule
`default_nettype wire

// ### tx_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_config_params.svh"

module tx_config_asserts (
  input wire logic       ref_clk,            // Clock.
  input wire logic       srst,               // Reset.
  input wire logic [7:0] regAddr,            // Address.
  input wire logic [7:0] regWdata,           // Write data.
  input wire logic       regWrite,           // Write strobe.
  input wire logic       regRead,            // Read strobe.
  input wire logic [7:0] regRdata,           // Read data.
  input wire logic       rfEnable,           // RF on.
  input wire logic       rxEnable,           // Receiver on.
  input wire logic       ccaMulti,           // Multi check.
  input wire logic       loadReq,            // Packet load.
  input wire logic [7:0] dacCode,            // DAC code.
  input wire logic       paRangeHigh,        // PA range.
  input wire logic       modulationSelect,   // On-off keying.
  input wire logic       channelForceEnable, // Channel forced.
  input wire logic [3:0] forcedChannel,      // Forced channel.
  input wire logic       txBusy              // Busy.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence optWr;
    regWrite && regAddr == `TXC_ADDR_TXOPT;
  endsequence
  sequence startCmd;
    regWrite && regAddr == `TXC_ADDR_CMD && regWdata == `TXC_CMD_TX && !txBusy;
  endsequence
  sequence stopCmd;
    regWrite && regAddr == `TXC_ADDR_CMD &&
      (regWdata == `TXC_CMD_IDLE || regWdata == `TXC_CMD_RETURN);
  endsequence

  a_read_stands: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data outside its slot");
  a_opt_bit3: assert property (
    regRead && regAddr == `TXC_ADDR_TXOPT |=> !regRdata[3])
    else $error("unused option bit reads one");
  a_mod_select: assert property (
    optWr |=> modulationSelect == $past(regWdata[0]))
    else $error("keying mode not taken from option bit 0");
  a_force_enable: assert property (
    optWr |=> channelForceEnable == $past(regWdata[5]))
    else $error("channel force not taken from option bit 5");
  a_multi_check: assert property (
    optWr |=> ccaMulti == ($past(regWdata[7:6]) == 2'b10))
    else $error("multi channel check flag wrong");
  a_force_chan: assert property (
    regWrite && regAddr == `TXC_ADDR_STAT2 && channelForceEnable
    |=> forcedChannel == $past(regWdata[7:4]))
    else $error("forced channel nibble not written");
  a_pa_range: assert property (
    regWrite && regAddr == `TXC_ADDR_POWER
    |=> paRangeHigh == $past(regWdata[7]))
    else $error("PA range not taken from power bit 7");
  a_dac_lsb: assert property (dacCode[0] == 1'b0)
    else $error("DAC low bit not zero");
  a_dac_code: assert property (
    regWrite && regAddr == `TXC_ADDR_POWER
    |=> ##1 txBusy || dacCode == {$past(regWdata[6:0], 2), 1'b0})
    else $error("DAC code not taken from power bits 6:0");
  a_check_first: assert property (rxEnable |-> txBusy && !rfEnable)
    else $error("RF on during channel check");
  a_load_first: assert property (loadReq |-> !rfEnable)
    else $error("RF on before packet loaded");
  a_start_busy: assert property (startCmd |=> txBusy)
    else $error("start command did not start transmit");
  a_stop_idle: assert property (stopCmd |=> !txBusy && !rfEnable)
    else $error("stop command did not end transmit");
endmodule

bind tx_config_preamble_regs tx_config_asserts u_checker (
  .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .rfEnable(rfEnable), .rxEnable(rxEnable), .ccaMulti(ccaMulti),
  .loadReq(loadReq), .dacCode(dacCode), .paRangeHigh(paRangeHigh),
  .modulationSelect(modulationSelect),
  .channelForceEnable(channelForceEnable),
  .forcedChannel(forcedChannel), .txBusy(txBusy)
);
`default_nettype wire

// ### host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_config_params.svh"

module host_bus_model (
  input  wire logic       ref_clk,  // Clock.
  output var  logic [7:0] regAddr,  // Address.
  output var  logic [7:0] regWdata, // Write data.
  output var  logic       regWrite, // Write strobe.
  output var  logic       regRead,  // Read strobe.
  input  wire logic [7:0] regRdata  // Read data.
);
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // Released lines show the inverse so stale values are never trusted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `TXC_ADDR_TXOPT && v[7:6] == 2'b11) v[7:6] = 2'b00;
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_config_params.svh"

module testbench;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata, dacCode, rd, v;
  logic       regWrite, regRead, rfEnable, rxEnable, ccaMulti, loadReq;
  logic       txBit, paRangeHigh, modulationSelect, channelForceEnable;
  logic       txBusy;
  logic [3:0] freqLevel, forcedChannel;
  logic [4:0] pulseVec = 5'h00;
  logic       txDataPin = 1'b0;
  logic       energyDetect = 1'b0;
  logic [7:0] chipId = 8'h00;
  logic [7:0] globalId = 8'h00;
  int         errorCnt = 0;
  int         checksDone = 0;

  host_bus_model hostBus (.ref_clk(ref_clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata));

  tx_config_preamble_regs #(.ID_WIDTH(8)) i_tx_config_preamble_regs (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .bitTick(pulseVec[0]), .shapeTick(pulseVec[1]), .txDataPin(txDataPin),
    .burstStart(pulseVec[2]), .ccaDone(pulseVec[3]),
    .energyDetect(energyDetect), .pktLoaded(pulseVec[4]), .chipId(chipId),
    .globalId(globalId), .rfEnable(rfEnable), .rxEnable(rxEnable),
    .ccaMulti(ccaMulti), .loadReq(loadReq), .txBit(txBit),
    .freqLevel(freqLevel), .dacCode(dacCode), .paRangeHigh(paRangeHigh),
    .modulationSelect(modulationSelect),
    .channelForceEnable(channelForceEnable),
    .forcedChannel(forcedChannel), .txBusy(txBusy));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] gauss(input int k);
    logic [3:0] tbl [16] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6,
                             4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hE, 4'hF, 4'hF};
    return tbl[k];
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checksDone++;
    if (s !== e) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // Bits: 0 bit tick, 1 shape tick, 2 burst start, 3 check done, 4 loaded.
  task automatic pulse(input int i);
    @(posedge ref_clk);
    pulseVec[i] <= 1'b1;
    @(posedge ref_clk);
    pulseVec <= 5'h00;
    #1;
  endtask

  task automatic start(input logic [7:0] opt, input int n, input bit burst);
    hostBus.wr(`TXC_ADDR_TXOPT, opt);
    hostBus.wr(`TXC_ADDR_PRE, 8'(n));
    if (burst) pulse(2);
    else hostBus.wr(`TXC_ADDR_CMD, `TXC_CMD_TX);
    #1;
  endtask

  task automatic stop(input logic [7:0] cmd = `TXC_CMD_IDLE);
    hostBus.wr(`TXC_ADDR_CMD, cmd);
    #1;
    chk("txBusy", 8'h00, {7'h00, txBusy});
  endtask

  task automatic preRun(input logic [7:0] opt, input int n, input bit burst);
    start(opt, n, burst);
    for (int k = 0; k < n; k++) begin
      chk("rfEnable", 8'h01, {7'h00, rfEnable});
      pulse(0);
      chk("txBit", {7'h00, opt[0] | ~k[0]}, {7'h00, txBit});
      @(posedge ref_clk);
      #1;
      if (opt[1:0] == 2'b00) begin
        chk("freqLevel", {4'h0, {4{~k[0]}}}, 8'(freqLevel));
      end
    end
  endtask

  task automatic idRun(input logic [2:0] aux, input logic [7:0] opt);
    logic [7:0] id;
    id = opt[2] ? chipId : globalId;
    hostBus.wr(`TXC_ADDR_AUX, {5'h00, aux});
    preRun(opt, 1, 1'b0);
    for (int k = 7; k >= 0; k--) begin
      pulse(0);
      chk("idBit", {7'h00, aux[0] & id[k]}, {7'h00, txBit});
    end
    stop();
  endtask

  task automatic finalReport();
    if (errorCnt == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    finalReport();
  end

  initial begin
    void'($urandom(32'h091D));
    chipId = 8'h80 | 8'($urandom);
    globalId = 8'h01 | 8'($urandom);
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      v[7:6] = 2'($urandom_range(2));
      hostBus.wr(`TXC_ADDR_TXOPT, v);
      hostBus.rd(`TXC_ADDR_TXOPT, rd);
      chk("txOpt", v & `TXC_TXOPT_MASK, rd);
      chk("modSel", {7'h00, v[0]}, {7'h00, modulationSelect});
      chk("ccaMulti", {7'h00, v[7:6] == 2'b10}, {7'h00, ccaMulti});
      v = 8'($urandom);
      hostBus.wr(`TXC_ADDR_POWER, v);
      @(posedge ref_clk);
      #1;
      chk("paRange", {7'h00, v[7]}, {7'h00, paRangeHigh});
      chk("dacCode", {v[6:0], 1'b0}, dacCode);
      hostBus.wr(`TXC_ADDR_PRE, v ^ 8'h5A);
      hostBus.rd(`TXC_ADDR_PRE, rd);
      chk("preLen", v ^ 8'h5A, rd);
    end
    hostBus.rd(8'h55, rd);
    chk("unmapped", 8'h00, rd);
    hostBus.wr(`TXC_ADDR_TXOPT, 8'h00);
    hostBus.wr(`TXC_ADDR_STAT2, 8'hF0);
    #1;
    chk("chanLocked", 8'h00, 8'(forcedChannel));
    hostBus.wr(`TXC_ADDR_TXOPT, 8'h20);
    hostBus.wr(`TXC_ADDR_STAT2, 8'hB0);
    #1;
    chk("chanForced", 8'h0B, 8'(forcedChannel));
    // Ten bit times of carrier suit on-off NRZ or Manchester with a start byte.
    preRun(8'h01, 10, 1'b0);
    stop();
    preRun(8'h00, 2 + $urandom_range(7), 1'b0);
    stop();
    preRun(8'h00, 3, 1'b1);
    stop();
    idRun(3'b001, 8'h04);
    idRun(3'b001, 8'h00);
    idRun(3'b000, 8'h04);
    start(8'h40, 2, 1'b0);
    chk("rxFirst", 8'h02, {6'h00, rxEnable, rfEnable});
    energyDetect <= 1'b1;
    pulse(3);
    chk("blocked", 8'h00, {7'h00, txBusy});
    hostBus.rd(`TXC_ADDR_STAT2, rd);
    chk("blockFlag", 8'h01, {7'h00, rd[1]});
    energyDetect <= 1'b0;
    start(8'h80, 2, 1'b0);
    chk("ccaMultiOn", 8'h01, {7'h00, ccaMulti});
    pulse(3);
    chk("clearGo", 8'h01, {6'h00, rxEnable, rfEnable});
    stop(`TXC_CMD_RETURN);
    hostBus.wr(`TXC_ADDR_AUX, 8'h07);
    start(8'h00, 2, 1'b0);
    chk("loadFirst", 8'h02, {6'h00, loadReq, rfEnable});
    pulse(4);
    chk("loaded", 8'h01, {6'h00, loadReq, rfEnable});
    stop();
    hostBus.wr(`TXC_ADDR_AUX, 8'h00);
    hostBus.wr(`TXC_ADDR_POWER, 8'h05);
    start(8'h10, 2, 1'b0);
    chk("rampLow", 8'h00, dacCode);
    repeat (60) @(posedge ref_clk);
    #1;
    chk("rampTop", 8'h0A, dacCode);
    stop();
    preRun(8'h02, 2, 1'b0);
    txDataPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pulse(0);
    @(posedge ref_clk);
    for (int k = 1; k < 16; k++) begin
      pulse(1);
      @(posedge ref_clk);
      #1;
      chk("shapeStep", {4'h0, gauss(k)}, 8'(freqLevel));
    end
    stop();
    // A second reset after the last transmit has stopped must bring the option register and the forced channel back to zero.
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    hostBus.rd(`TXC_ADDR_TXOPT, rd);
    chk("txOptReset", `TXC_TXOPT_RESET, rd);
    chk("chanReset", {4'h0, `TXC_CHAN_RESET}, 8'(forcedChannel));
    finalReport();
  end
endmodule
`default_nettype wire
